// ### logic/fpt_pkg.sv
// Purpose: shared constants and types for the flash program/erase timer
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   two register sets, one per flash array, 0x40 apart
package fpt_pkg;
   localparam logic [11:0] FPT_SET_STRIDE     = 12'h040;
   localparam logic [5:0]  FPT_OFF_PRESCALE   = 6'h00;
   localparam logic [5:0]  FPT_OFF_START      = 6'h04;
   localparam logic [5:0]  FPT_OFF_TRAN       = 6'h08;
   localparam logic [5:0]  FPT_OFF_PROG       = 6'h0C;
   localparam logic [5:0]  FPT_OFF_PERASE     = 6'h10;
   localparam logic [5:0]  FPT_OFF_MERASE     = 6'h14;
   localparam logic [5:0]  FPT_OFF_END        = 6'h18;
   localparam logic [5:0]  FPT_OFF_MEND       = 6'h1C;
   localparam logic [5:0]  FPT_OFF_RCV        = 6'h20;
   localparam logic [5:0]  FPT_OFF_CTRL       = 6'h24;
   localparam logic [5:0]  FPT_OFF_STATUS     = 6'h28;
   // control register fields: write of a non-zero op code while not busy starts an operation
   localparam int          FPT_CTRL_OP_LSB    = 0;
   localparam int          FPT_STAT_BUSY_BIT  = 0;
   localparam int          FPT_STAT_PH_LSB    = 4;
   localparam logic [7:0]  FPT_PRESCALE_RST   = 8'h00;
   localparam logic [15:0] FPT_COUNT_RST      = 16'hFFFF;
   localparam int          FPT_PROG_MULT_LOG2 = 3;
   localparam int          FPT_ERASE_MULT_LOG2 = 12;
   localparam int          FPT_MEND_MULT_LOG2 = 3;
   // least times and the program maximum, ns, and the cycles they need at the 10 ns clock
   localparam int          FPT_CLK_NS         = 10;
   localparam int          FPT_START_MIN_NS   = 5000;
   localparam int          FPT_TRAN_MIN_NS    = 10000;
   localparam int          FPT_PROG_MIN_NS    = 20000;
   localparam int          FPT_PROG_MAX_NS    = 40000;
   localparam int          FPT_PERASE_MIN_NS  = 20000000;
   localparam int          FPT_MERASE_MIN_NS  = 200000000;
   localparam int          FPT_END_MIN_NS     = 5000;
   localparam int          FPT_MEND_MIN_NS    = 100000;
   localparam int          FPT_RCV_MIN_NS     = 1000;
   localparam int          FPT_START_MIN_CYC  = (FPT_START_MIN_NS + FPT_CLK_NS - 1) / FPT_CLK_NS;
   localparam int          FPT_TRAN_MIN_CYC   = (FPT_TRAN_MIN_NS + FPT_CLK_NS - 1) / FPT_CLK_NS;
   localparam int          FPT_PROG_MIN_CYC   = (FPT_PROG_MIN_NS + FPT_CLK_NS - 1) / FPT_CLK_NS;
   localparam int          FPT_PROG_MAX_CYC   = FPT_PROG_MAX_NS / FPT_CLK_NS;
   localparam int          FPT_END_MIN_CYC    = (FPT_END_MIN_NS + FPT_CLK_NS - 1) / FPT_CLK_NS;
   localparam int          FPT_MEND_MIN_CYC   = (FPT_MEND_MIN_NS + FPT_CLK_NS - 1) / FPT_CLK_NS;
   localparam int          FPT_RCV_MIN_CYC    = (FPT_RCV_MIN_NS + FPT_CLK_NS - 1) / FPT_CLK_NS;
   localparam int          FPT_PERASE_MIN_CYC = (FPT_PERASE_MIN_NS + FPT_CLK_NS - 1) / FPT_CLK_NS;
   localparam int          FPT_MERASE_MIN_CYC = (FPT_MERASE_MIN_NS + FPT_CLK_NS - 1) / FPT_CLK_NS;

   typedef enum logic [1:0] {
      FPT_OP_NONE   = 2'b00,
      FPT_OP_PROG   = 2'b01,
      FPT_OP_PERASE = 2'b10,
      FPT_OP_MERASE = 2'b11
   } fpt_op_type;

   typedef enum logic [2:0] {
      FPT_PH_IDLE  = 3'b000,
      FPT_PH_START = 3'b001,
      FPT_PH_TRAN  = 3'b010,
      FPT_PH_PULSE = 3'b011,
      FPT_PH_HOLD  = 3'b100,
      FPT_PH_RCV   = 3'b101
   } fpt_phase_type;
endpackage : fpt_pkg

// ### logic/fpt_timer_if.sv
// Purpose: carries one array's timing values and run status between modules
// Assumes: single pclk domain
// Notes:   regs side owns the counts, sequencer side owns the busy and phase status
`timescale 1ns/10ps
`default_nettype none
interface fpt_timer_if;
   import fpt_pkg::*;
   logic [7:0]    prescale;
   logic [15:0]   cnt_start;
   logic [15:0]   cnt_tran;
   logic [15:0]   cnt_prog;
   logic [15:0]   cnt_perase;
   logic [15:0]   cnt_merase;
   logic [15:0]   cnt_end;
   logic [15:0]   cnt_mend;
   logic [15:0]   cnt_rcv;
   fpt_op_type    op_req;
   logic          op_go;
   logic          busy;
   fpt_phase_type phase;
   modport regs (output prescale, cnt_start, cnt_tran, cnt_prog, cnt_perase, cnt_merase,
                 cnt_end, cnt_mend, cnt_rcv, op_req, op_go, input busy, phase);
   modport seq  (input prescale, cnt_start, cnt_tran, cnt_prog, cnt_perase, cnt_merase,
                 cnt_end, cnt_mend, cnt_rcv, op_req, op_go, output busy, phase);
endinterface : fpt_timer_if
`default_nettype wire

// ### logic/fpt_sequencer.sv
// Purpose: runs one flash array's program/erase phase sequence
// Assumes: counts stable while busy
// Notes:   one prescaler and one down-counter shared by all phases
`timescale 1ns/10ps
`default_nettype none
module fpt_sequencer
   import fpt_pkg::*;
(
   input  wire logic   pclk,
   input  wire logic   presetn,
   fpt_timer_if.seq    tif,
   output logic        prog_en,
   output logic        erase_en,
   output logic        storage_strobe,
   output logic        access_ready
);
   fpt_phase_type phase_reg;
   fpt_op_type    op_reg;
   logic [7:0]    pre_reg;
   logic [27:0]   cnt_reg;
   logic          tick;
   logic [27:0]   load_val;

   assign tick = (pre_reg == 8'h00);

   // ticks for the next phase; multipliers are shifts of (count + 1)
   always_comb begin
      load_val = 28'h0000000;
      case (phase_reg)
         FPT_PH_START: load_val = {12'h000, tif.cnt_tran};
         FPT_PH_TRAN: begin
            if (op_reg == FPT_OP_PROG)
               load_val = ({12'h000, tif.cnt_prog} << FPT_PROG_MULT_LOG2)
                          + 28'h0000007;
            else if (op_reg == FPT_OP_PERASE)
               load_val = ({12'h000, tif.cnt_perase} << FPT_ERASE_MULT_LOG2)
                          + 28'h0000FFF;
            else
               load_val = ({12'h000, tif.cnt_merase} << FPT_ERASE_MULT_LOG2)
                          + 28'h0000FFF;
         end
         FPT_PH_PULSE: begin
            if (op_reg == FPT_OP_MERASE)
               load_val = ({12'h000, tif.cnt_mend} << FPT_MEND_MULT_LOG2)
                          + 28'h0000007;
            else
               load_val = {12'h000, tif.cnt_end};
         end
         FPT_PH_HOLD: load_val = {12'h000, tif.cnt_rcv};
         default: load_val = 28'h0000000;
      endcase
   end

   // prescaler restarts with each phase so every phase is a whole tick count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pre_reg <= FPT_PRESCALE_RST;
      else if (phase_reg == FPT_PH_IDLE || tick)
         pre_reg <= tif.prescale;
      else
         pre_reg <= pre_reg - 8'h01;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= FPT_PH_IDLE;
         op_reg    <= FPT_OP_NONE;
         cnt_reg   <= 28'h0000000;
      end else begin
         case (phase_reg)
            FPT_PH_IDLE: begin
               if (tif.op_go && tif.op_req != FPT_OP_NONE) begin
                  op_reg    <= tif.op_req;
                  cnt_reg   <= {12'h000, tif.cnt_start};
                  phase_reg <= FPT_PH_START;
               end
            end
            default: begin
               if (tick) begin
                  if (cnt_reg == 28'h0000000) begin
                     cnt_reg <= load_val;
                     case (phase_reg)
                        FPT_PH_START: phase_reg <= FPT_PH_TRAN;
                        FPT_PH_TRAN:  phase_reg <= FPT_PH_PULSE;
                        FPT_PH_PULSE: phase_reg <= FPT_PH_HOLD;
                        FPT_PH_HOLD:  phase_reg <= FPT_PH_RCV;
                        default:      phase_reg <= FPT_PH_IDLE;
                     endcase
                  end else
                     cnt_reg <= cnt_reg - 28'h0000001;
               end
            end
         endcase
      end
   end

   // program/erase line stays high from setup through the pulse; strobe from
   // transition setup through hold, so it falls as recovery starts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_en        <= 1'b0;
         erase_en       <= 1'b0;
         storage_strobe <= 1'b0;
      end else begin
         prog_en        <= (phase_next_in(phase_reg) && op_reg == FPT_OP_PROG);
         erase_en       <= (phase_next_in(phase_reg) && op_reg != FPT_OP_PROG
                            && op_reg != FPT_OP_NONE);
         storage_strobe <= (phase_reg == FPT_PH_TRAN || phase_reg == FPT_PH_PULSE
                            || phase_reg == FPT_PH_HOLD);
      end
   end

   function automatic logic phase_next_in(input fpt_phase_type p);
      phase_next_in = (p == FPT_PH_START || p == FPT_PH_TRAN || p == FPT_PH_PULSE);
   endfunction : phase_next_in

   assign access_ready = (phase_reg == FPT_PH_IDLE);
   assign tif.busy     = (phase_reg != FPT_PH_IDLE);
   assign tif.phase    = phase_reg;
endmodule : fpt_sequencer
`default_nettype wire

// ### logic/fpt_flash_timer.sv
// Purpose: APB-programmed timing sequencer for flash program and erase
// Assumes: pclk at 100 MHz, software never writes timing counts while busy
// Notes:   set 0 times the program array, set 1 the data array
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - program/erase to strobe lasts (prescale+1)*(start+1) clocks, at least 5 us
// - strobe to pulse lasts (prescale+1)*(transition+1) clocks, at least 10 us
// - program pulse lasts (prescale+1)*8*(program+1) clocks, 20 to 40 us
// - page erase pulse lasts (prescale+1)*4096*(page erase+1), at least 20 ms
// - array erase pulse lasts (prescale+1)*4096*(array erase+1), at least 200 ms
// - strobe held (prescale+1)*(end+1) clocks after program or page erase
// - strobe held (prescale+1)*8*(array end+1) clocks after array erase
// - recovery (prescale+1)*(recovery+1)-1 clocks after strobe drops, before next access
// - two independent register sets, one per flash array
module fpt_flash_timer
   import fpt_pkg::*;
#(
   parameter int NUM_ARRAYS = 2
)(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic      [NUM_ARRAYS-1:0] prog_en,
   output logic      [NUM_ARRAYS-1:0] erase_en,
   output logic      [NUM_ARRAYS-1:0] storage_strobe,
   output logic      [NUM_ARRAYS-1:0] access_ready
);
   logic                  wr_en;
   logic                  rd_en;
   logic                  addr_ok;
   logic [31:0]           rd_mux;
   logic [31:0]           rd_set [NUM_ARRAYS];

   function automatic logic [5:0] reg_off(input logic [11:0] a);
      reg_off = a[5:0];
   endfunction : reg_off

   function automatic int set_of(input logic [11:0] a);
      set_of = int'(a[11:6]);
   endfunction : set_of

   assign addr_ok = (set_of(paddr) < NUM_ARRAYS) && (paddr[1:0] == 2'b00)
                    && (reg_off(paddr) <= FPT_OFF_STATUS);
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   genvar g;
   generate
      for (g = 0; g < NUM_ARRAYS; g++) begin : g_set
         fpt_timer_if tif ();
         logic [7:0]  pre_reg;
         logic [15:0] cnt_reg [8];
         logic        go_reg;
         fpt_op_type  op_reg;
         logic        hit;

         assign hit = wr_en && addr_ok && (set_of(paddr) == g);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               pre_reg <= FPT_PRESCALE_RST;
            else if (hit && reg_off(paddr) == FPT_OFF_PRESCALE)
               pre_reg <= pwdata[7:0];
         end

         for (genvar k = 0; k < 8; k++) begin : g_cnt
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn)
                  cnt_reg[k] <= FPT_COUNT_RST;
               else if (hit && reg_off(paddr) == 6'(FPT_OFF_START + 6'(4 * k)))
                  cnt_reg[k] <= pwdata[15:0];
            end
         end

         // start is a one-cycle pulse; control writes while busy are dropped
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               go_reg <= 1'b0;
               op_reg <= FPT_OP_NONE;
            end else begin
               go_reg <= hit && reg_off(paddr) == FPT_OFF_CTRL && !tif.busy;
               if (hit && reg_off(paddr) == FPT_OFF_CTRL && !tif.busy)
                  op_reg <= fpt_op_type'(pwdata[FPT_CTRL_OP_LSB +: 2]);
            end
         end

         assign tif.prescale   = pre_reg;
         assign tif.cnt_start  = cnt_reg[0];
         assign tif.cnt_tran   = cnt_reg[1];
         assign tif.cnt_prog   = cnt_reg[2];
         assign tif.cnt_perase = cnt_reg[3];
         assign tif.cnt_merase = cnt_reg[4];
         assign tif.cnt_end    = cnt_reg[5];
         assign tif.cnt_mend   = cnt_reg[6];
         assign tif.cnt_rcv    = cnt_reg[7];
         assign tif.op_req     = op_reg;
         assign tif.op_go      = go_reg;

         fpt_sequencer u_seq (
            .pclk           (pclk),
            .presetn        (presetn),
            .tif            (tif),
            .prog_en        (prog_en[g]),
            .erase_en       (erase_en[g]),
            .storage_strobe (storage_strobe[g]),
            .access_ready   (access_ready[g])
         );

         always_comb begin
            rd_set[g] = 32'h00000000;
            case (reg_off(paddr))
               FPT_OFF_PRESCALE: rd_set[g] = {24'h000000, pre_reg};
               FPT_OFF_CTRL:     rd_set[g] = {30'h00000000, op_reg};
               FPT_OFF_STATUS:   rd_set[g] = {25'h0000000, tif.phase, 3'b000, tif.busy};
               default: begin
                  if (reg_off(paddr) >= FPT_OFF_START && reg_off(paddr) <= FPT_OFF_RCV)
                     rd_set[g] = {16'h0000, cnt_reg[3'(reg_off(paddr) >> 2) - 3'h1]};
               end
            endcase
         end
      end
   endgenerate

   always_comb begin
      rd_mux = 32'h00000000;
      for (int i = 0; i < NUM_ARRAYS; i++) begin
         if (set_of(paddr) == i)
            rd_mux = rd_set[i];
      end
   end

   // read data is captured in setup so it is a flop during the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_en)
         prdata <= addr_ok ? rd_mux : 32'h00000000;
   end
endmodule : fpt_flash_timer
`default_nettype wire

// ### verif/fpt_flash_timer_asserts.sv
// Purpose: port-level checks of the flash program/erase timer
// Assumes: single pclk domain, reset held low asynchronously
// Notes:   sequence checks watch array 0; vector checks cover every array
`timescale 1ns/10ps
`default_nettype none
module fpt_flash_timer_asserts
   import fpt_pkg::*;
#(
   parameter int NUM_ARRAYS = 2
)(
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic [NUM_ARRAYS-1:0] prog_en,
   input wire logic [NUM_ARRAYS-1:0] erase_en,
   input wire logic [NUM_ARRAYS-1:0] storage_strobe,
   input wire logic [NUM_ARRAYS-1:0] access_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [NUM_ARRAYS-1:0] act = prog_en | erase_en;
   sequence s_drive_up;
      ##[1:2] act[0];
   endsequence
   sequence s_released;
      !storage_strobe[0] && !act[0];
   endsequence
   property p_launch;
      $fell(access_ready[0]) |-> s_drive_up;
   endproperty
   a_launch: assert property (p_launch) else $error("enable late after leaving idle");
   property p_strobe_after_en;
      $rose(storage_strobe[0]) |-> act[0] && $past(act[0]);
   endproperty
   a_strobe_after_en: assert property (p_strobe_after_en) else $error("strobe too early");
   property p_no_early_strobe;
      $rose(act[0]) |-> !storage_strobe[0];
   endproperty
   a_no_early_strobe: assert property (p_no_early_strobe) else $error("strobe at enable");
   property p_hold;
      $fell(act[0]) |-> storage_strobe[0];
   endproperty
   a_hold: assert property (p_hold) else $error("strobe not held after pulse");
   property p_release;
      $fell(storage_strobe[0]) |-> !act[0];
   endproperty
   a_release: assert property (p_release) else $error("strobe dropped during pulse");
   property p_excl;
      (prog_en & erase_en) == '0;
   endproperty
   a_excl: assert property (p_excl) else $error("program and erase together");
   property p_busy;
      ((act | storage_strobe) & access_ready) == '0;
   endproperty
   a_busy: assert property (p_busy) else $error("ready while active");
   property p_idle_clean;
      $rose(access_ready[0]) |-> s_released;
   endproperty
   a_idle_clean: assert property (p_idle_clean) else $error("ready before release");
   // error exactly in the access phase of an unmapped or misaligned address
   property p_slverr;
      pslverr == (psel && penable && (paddr[1:0] != 2'b00
                  || paddr[11:6] >= 6'(NUM_ARRAYS) || paddr[5:0] > FPT_OFF_STATUS));
   endproperty
   a_slverr: assert property (p_slverr) else $error("error outside access phase");
endmodule : fpt_flash_timer_asserts
bind fpt_flash_timer fpt_flash_timer_asserts #(.NUM_ARRAYS(NUM_ARRAYS)) fpt_flash_timer_asserts_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .prog_en(prog_en), .erase_en(erase_en), .storage_strobe(storage_strobe),
   .access_ready(access_ready));
`default_nettype wire

// ### verif/tb_fpt_flash_timer.sv
// Purpose: self-checking bench of the flash program/erase timer
// Assumes: zero-wait APB slave, one operation in flight at a time
// Notes:   phase lengths are measured between output edges
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) chk(64'(a), 64'(e))
module tb_fpt_flash_timer;
   import fpt_pkg::*;
   logic            pclk = 0;
   logic            presetn = 0;
   logic            psel = 0;
   logic            penable = 0;
   logic            pwrite = 0;
   logic [11:0]     paddr = '0;
   logic [31:0]     pwdata = '0;
   wire logic [31:0] prdata;
   wire logic       pready;
   wire logic       pslverr;
   wire logic [1:0] prog_en;
   wire logic [1:0] erase_en;
   wire logic [1:0] storage_strobe;
   wire logic [1:0] access_ready;
   int              n_errors = 0;
   int              compares = 0;
   int              cyc = 0;
   logic [32:0]     rd_q[$];
   int              iv_q[$];
   logic            en_q = 0;
   logic            st_q = 0;
   logic            rdy_q = 1;
   always #5 pclk = ~pclk;
   fpt_flash_timer #(.NUM_ARRAYS(2)) fpt_flash_timer_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_en(prog_en), .erase_en(erase_en), .storage_strobe(storage_strobe),
      .access_ready(access_ready));
   task automatic chk(input logic [63:0] a, input logic [63:0] e);
      compares++;
      if (a !== e) begin
         n_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, a, e);
      end
   endtask : chk
   task automatic end_of_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // read data and error are judged at the access edge, the only edge they count
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1)
         `CHK({pslverr, prdata}, rd_q.pop_front());
   end
   // edges sampled before the edge's own updates, so every interval is seen alike
   always @(posedge pclk) begin : watch
      logic en, st, ry;
      en = |(prog_en | erase_en);
      st = |storage_strobe;
      ry = &access_ready;
      if (en && !en_q) cyc = 1;
      else if (st != st_q || (!en && en_q) || (ry && !rdy_q)) begin
         `CHK(cyc, iv_q.pop_front());
         cyc = 1;
      end else cyc++;
      en_q  = en;
      st_q  = st;
      rdy_q = ry;
   end
   task automatic run_op(input logic [11:0] b, input fpt_op_type op, input logic [7:0] p);
      int c[8];
      int m;
      int k;
      logic [1:0] sel;
      m = p + 1;
      sel = 2'b01 << b[6];
      // erase counts kept at 0..1 so the run stays short; pulses stay far below the
      // cumulative exposure budget of a row
      for (k = 0; k < 8; k++) c[k] = $urandom_range((k == 3 || k == 4) ? 1 : 3);
      c[0] = 3;
      apb(1'b1, b + 12'(FPT_OFF_PRESCALE), {24'h000000, p});
      for (k = 0; k < 8; k++) apb(1'b1, b + 12'(FPT_OFF_START) + 12'(4 * k), 32'(c[k]));
      iv_q.push_back(m * (c[0] + 1));
      iv_q.push_back(m * (c[1] + 1) + m * (op == FPT_OP_PROG ? 8 * (c[2] + 1) :
                     4096 * (c[op == FPT_OP_PERASE ? 3 : 4] + 1)));
      iv_q.push_back(m * (op == FPT_OP_MERASE ? 8 * (c[6] + 1) : c[5] + 1));
      iv_q.push_back(m * (c[7] + 1) - 1);
      apb(1'b1, b + 12'(FPT_OFF_CTRL), 32'(op));
      k = 0;
      while (!(|(prog_en | erase_en)) && k < 50) begin
         @(posedge pclk);
         k++;
      end
      `CHK(k < 50, 1'b1);
      `CHK({prog_en, erase_en, storage_strobe}, {op == FPT_OP_PROG ? sel : 2'b00, op == FPT_OP_PROG ? 2'b00 : sel, 2'b00});
      rd(b + 12'(FPT_OFF_STATUS), {1'b0, 25'h0, FPT_PH_START, 3'h0, 1'b1});
      // a start while busy must leave the running operation untouched
      apb(1'b1, b + 12'(FPT_OFF_CTRL), 32'(FPT_OP_PROG));
      rd(b + 12'(FPT_OFF_CTRL), {1'b0, 30'h0, op});
      k = 0;
      while (iv_q.size() != 0 && k < 40000) begin
         @(posedge pclk);
         k++;
      end
      `CHK(k < 40000, 1'b1);
      rd(b + 12'(FPT_OFF_STATUS), 33'h0);
   endtask : run_op
   initial begin
      void'($urandom(32'h7FD40048));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int s = 0; s < 2; s++)
         for (int k = 0; k < 9; k++)
            rd(12'(64 * s + 4 * k), k == 0 ? 33'h0 : {17'h0, FPT_COUNT_RST});
      rd(12'h02C, 33'h100000000);
      rd(12'h006, 33'h100000000);
      run_op(12'h000, FPT_OP_PROG, 8'h02);
      rd(12'h040 + 12'(FPT_OFF_START), {17'h0, FPT_COUNT_RST});
      run_op(12'h040, FPT_OP_PERASE, 8'h01);
      run_op(12'h040, FPT_OP_MERASE, 8'h01);
      end_of_test;
   end
   // two erases of at most about 17k cycles each; the limit leaves ample margin
   initial begin
      #900000;
      n_errors++;
      end_of_test;
   end
endmodule : tb_fpt_flash_timer
`default_nettype wire
